// ===== scsc_pkg.sv
// Constants for the system clock select control block
package scsc_pkg;
  localparam logic [31:0] OFF_OSC_CTRL    = 32'h0000_0000;
  localparam logic [31:0] OFF_TMR1_CTRL   = 32'h0000_0004;
  localparam logic [31:0] OFF_OSC_TUNE    = 32'h0000_0008;
  localparam logic [31:0] OFF_SLEEP_CMD   = 32'h0000_000C;
  localparam int BIT_IDLE_ON_SLEEP  = 7;
  localparam int BIT_FREQ_LO        = 4;
  localparam int BIT_STARTUP_TO     = 3;
  localparam int BIT_INT_STABLE     = 2;
  localparam int BIT_SEC_RUNNING    = 6;
  localparam int BIT_SEC_OSC_EN     = 3;
  localparam int BIT_LOW_FREQ_SRC   = 7;
  localparam logic [1:0] SRC_PRIMARY   = 2'h0;
  localparam logic [1:0] SRC_SECONDARY = 2'h1;
  localparam logic [2:0] FREQ_RESET    = 3'h4;
  localparam logic [2:0] FREQ_31K      = 3'h0;
  localparam logic [2:0] FREQ_8M       = 3'h7;
  localparam int OLD_PAUSE_CYCLES   = 2;
  localparam int NEW_PAUSE_CYCLES   = 4;
  localparam int POSTSCALE_31K_LOG2 = 8;
  localparam logic [7:0] PAUSE_CNT_W0 = 8'h00;
  typedef enum logic [1:0] {SCSC_RUN, SCSC_OLD, SCSC_NEW} scsc_sw_t;
  typedef enum logic [1:0] {SCSC_ACTIVE, SCSC_IDLE, SCSC_SLEEP} scsc_pm_t;
endpackage

// ===== scsc_edge_sync.sv
// Two-flop synchroniser with a rising-edge pulse from the synchronised level
`timescale 1ns/1ps
`default_nettype none
module scsc_edge_sync (
  input  wire logic i_ref_clk,
  input  wire logic i_resetn,
  input  wire logic i_async,
  output logic      o_level,
  output logic      o_rise
);
  logic meta;
  logic prev;
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta    <= 1'b0;
      o_level <= 1'b0;
      prev    <= 1'b0;
    end else begin
      meta    <= i_async;
      o_level <= meta;
      prev    <= o_level;
    end
  end
  assign o_rise = o_level & ~prev;
endmodule
`default_nettype wire

// ===== scsc_top.sv
// System clock select control: registers, switch sequencer and status flags
`timescale 1ns/1ps
`default_nettype none
module scsc_top
  import scsc_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_resetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        i_primary_clk,
  input  wire logic        i_secondary_clk,
  input  wire logic        i_lprc_clk,
  input  wire logic        i_main_internal_oscillator_clk,
  input  wire logic        i_ost_expired,
  input  wire logic        i_int_stable,
  input  wire logic        i_two_speed_startup_config,
  output logic [1:0]       o_active_source,
  output logic [2:0]       o_int_freq,
  output logic             o_int_31k_from_main_internal_oscillator,
  output logic             o_sys_clk_enable,
  output logic             o_wdt_clk_from_lprc,
  output logic             o_idle_mode,
  output logic             o_sleep_mode
);
  // Register state
  logic [1:0] sys_src_sel;
  logic [2:0] int_freq_sel;
  logic       idle_on_sleep;
  logic       sec_osc_enable;
  logic       low_freq_source_flag;
  logic       startup_timeout_flag;
  logic       internal_stable_flag;
  logic       secondary_clock_running;
  logic [1:0] cur_src;
  logic [1:0] tgt_src;
  scsc_sw_t   sw_state;
  scsc_pm_t   pm_state;
  logic [7:0] pause_cnt;

  // Bus address phase capture
  logic        dp_valid;
  logic        dp_write;
  logic [31:0] dp_addr;
  logic        ap_take;
  assign ap_take = hsel & hready & htrans[1];

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr  <= 32'h0000_0000;
    end else if (hready) begin
      dp_valid <= ap_take;
      dp_write <= hwrite;
      dp_addr  <= haddr;
    end
  end

  logic wr_osc;
  logic wr_tmr1;
  logic wr_tune;
  logic wr_sleep;
  assign wr_osc   = dp_valid & dp_write & (dp_addr == OFF_OSC_CTRL);
  assign wr_tmr1  = dp_valid & dp_write & (dp_addr == OFF_TMR1_CTRL);
  assign wr_tune  = dp_valid & dp_write & (dp_addr == OFF_OSC_TUNE);
  assign wr_sleep = dp_valid & dp_write & (dp_addr == OFF_SLEEP_CMD);

  // Source clocks sampled into the reference domain; edges count pauses
  logic prim_lvl;
  logic prim_rise;
  logic sec_lvl;
  logic sec_rise;
  logic lprc_lvl;
  logic lprc_rise;
  logic iosc_lvl;
  logic iosc_rise;
  logic ost_lvl;
  logic ist_lvl;
  logic tss_lvl;
  scsc_edge_sync u_sync_prim (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_async   (i_primary_clk),
    .o_level   (prim_lvl),
    .o_rise    (prim_rise)
  );
  scsc_edge_sync u_sync_sec (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_async   (i_secondary_clk),
    .o_level   (sec_lvl),
    .o_rise    (sec_rise)
  );
  scsc_edge_sync u_sync_lprc (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_async   (i_lprc_clk),
    .o_level   (lprc_lvl),
    .o_rise    (lprc_rise)
  );
  scsc_edge_sync u_sync_iosc (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_async   (i_main_internal_oscillator_clk),
    .o_level   (iosc_lvl),
    .o_rise    (iosc_rise)
  );
  scsc_edge_sync u_sync_ost (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_async   (i_ost_expired),
    .o_level   (ost_lvl),
    .o_rise    ()
  );
  scsc_edge_sync u_sync_ist (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_async   (i_int_stable),
    .o_level   (ist_lvl),
    .o_rise    ()
  );
  scsc_edge_sync u_sync_tss (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_async   (i_two_speed_startup_config),
    .o_level   (tss_lvl),
    .o_rise    ()
  );

  // Edge of a given source; the internal block edge depends on frequency
  function automatic logic src_edge(input logic [1:0] s);
    if (s == SRC_PRIMARY) begin
      src_edge = prim_rise;
    end else if (s == SRC_SECONDARY) begin
      src_edge = sec_rise;
    end else if (int_freq_sel == FREQ_31K && !low_freq_source_flag) begin
      src_edge = lprc_rise;
    end else begin
      src_edge = iosc_rise;
    end
  endfunction

  // Control fields; reset clears the source select
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sys_src_sel   <= SRC_PRIMARY;
      int_freq_sel  <= FREQ_RESET;
      idle_on_sleep <= 1'b0;
    end else if (wr_osc) begin
      sys_src_sel   <= hwdata[1:0];
      int_freq_sel  <= hwdata[BIT_FREQ_LO +: 3];
      idle_on_sleep <= hwdata[BIT_IDLE_ON_SLEEP];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sec_osc_enable       <= 1'b0;
      low_freq_source_flag <= 1'b0;
    end else begin
      if (wr_tmr1) begin
        sec_osc_enable <= hwdata[BIT_SEC_OSC_EN];
      end
      if (wr_tune) begin
        low_freq_source_flag <= hwdata[BIT_LOW_FREQ_SRC];
      end
    end
  end

  // Glitch-free switch: two old edges, then four new edges with clock held.
  // Both 1x codes name the internal block, so 10 to 11 is no switch and a
  // frequency change there keeps running without a pause.
  logic [1:0] sel_src;
  logic       want_switch;
  assign sel_src     = {sys_src_sel[1],
                        sys_src_sel[0] & ~sys_src_sel[1]};
  assign want_switch = (sel_src != cur_src);
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sw_state  <= SCSC_RUN;
      cur_src   <= SRC_PRIMARY;
      tgt_src   <= SRC_PRIMARY;
      pause_cnt <= PAUSE_CNT_W0;
      o_sys_clk_enable <= 1'b1;
    end else begin
      case (sw_state)
        SCSC_RUN: begin
          if (want_switch) begin
            tgt_src   <= sel_src;
            sw_state  <= SCSC_OLD;
            pause_cnt <= PAUSE_CNT_W0;
          end
        end
        SCSC_OLD: begin
          if (src_edge(cur_src)) begin
            if (pause_cnt == 8'(OLD_PAUSE_CYCLES - 1)) begin
              o_sys_clk_enable <= 1'b0;
              sw_state  <= SCSC_NEW;
              pause_cnt <= PAUSE_CNT_W0;
            end else begin
              pause_cnt <= pause_cnt + 8'h01;
            end
          end
        end
        SCSC_NEW: begin
          if (src_edge(tgt_src)) begin
            if (pause_cnt == 8'(NEW_PAUSE_CYCLES - 1)) begin
              cur_src   <= tgt_src;
              o_sys_clk_enable <= 1'b1;
              sw_state  <= SCSC_RUN;
            end else begin
              pause_cnt <= pause_cnt + 8'h01;
            end
          end
        end
        default: begin
          sw_state <= SCSC_RUN;
        end
      endcase
    end
  end

  // Sleep command; a secondary choice without its oscillator is refused
  logic     sec_blocked;
  scsc_pm_t next_pm_state;
  assign sec_blocked = (sys_src_sel == SRC_SECONDARY) && !sec_osc_enable;
  always_comb begin
    next_pm_state = pm_state;
    if (wr_sleep) begin
      if (hwdata[0] && !sec_blocked) begin
        next_pm_state = idle_on_sleep ? SCSC_IDLE : SCSC_SLEEP;
      end else if (!hwdata[0]) begin
        next_pm_state = SCSC_ACTIVE;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pm_state <= SCSC_ACTIVE;
    end else begin
      pm_state <= next_pm_state;
    end
  end

  // Status flags: only the flag of the source now driving can be set
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      startup_timeout_flag    <= 1'b0;
      internal_stable_flag    <= 1'b0;
      secondary_clock_running <= 1'b0;
    end else begin
      startup_timeout_flag    <= (sw_state == SCSC_RUN)
                                 && (cur_src == SRC_PRIMARY)
                                 && (ost_lvl || tss_lvl);
      internal_stable_flag    <= (sw_state == SCSC_RUN)
                                 && cur_src[1] && ist_lvl
                                 && !(int_freq_sel == FREQ_31K
                                      && !low_freq_source_flag);
      secondary_clock_running <= (sw_state == SCSC_RUN)
                                 && (cur_src == SRC_SECONDARY);
    end
  end

  // Clock-tree steering outputs, registered
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_active_source       <= SRC_PRIMARY;
      o_int_freq            <= FREQ_RESET;
      o_int_31k_from_main_internal_oscillator <= 1'b0;
      o_wdt_clk_from_lprc   <= 1'b1;
      o_idle_mode           <= 1'b0;
      o_sleep_mode          <= 1'b0;
    end else begin
      o_active_source       <= cur_src;
      o_int_freq            <= int_freq_sel;
      o_int_31k_from_main_internal_oscillator <= (int_freq_sel == FREQ_31K)
                               && low_freq_source_flag;
      o_wdt_clk_from_lprc   <= 1'b1;
      o_idle_mode           <= (pm_state == SCSC_IDLE);
      o_sleep_mode          <= (pm_state == SCSC_SLEEP);
    end
  end

  // Read data; unmapped addresses read zero, response always OKAY.
  // A write lands on the same edge as a following read's address phase,
  // so that read takes the value being written, not the stale one.
  logic [1:0] rd_src;
  logic [2:0] rd_freq;
  logic       rd_idle;
  logic       rd_sec_en;
  logic       rd_low_freq;
  assign rd_src      = wr_osc ? hwdata[1:0] : sys_src_sel;
  assign rd_freq     = wr_osc ? hwdata[BIT_FREQ_LO +: 3] : int_freq_sel;
  assign rd_idle     = wr_osc ? hwdata[BIT_IDLE_ON_SLEEP] : idle_on_sleep;
  assign rd_sec_en   = wr_tmr1 ? hwdata[BIT_SEC_OSC_EN] : sec_osc_enable;
  assign rd_low_freq = wr_tune ? hwdata[BIT_LOW_FREQ_SRC]
                               : low_freq_source_flag;
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_take && !hwrite) begin
      hrdata <= 32'h0000_0000;
      case (haddr)
        OFF_OSC_CTRL: begin
          hrdata[1:0] <= rd_src;
          hrdata[BIT_INT_STABLE] <= internal_stable_flag;
          hrdata[BIT_STARTUP_TO] <= startup_timeout_flag;
          hrdata[BIT_FREQ_LO +: 3] <= rd_freq;
          hrdata[BIT_IDLE_ON_SLEEP] <= rd_idle;
        end
        OFF_TMR1_CTRL: begin
          hrdata[BIT_SEC_OSC_EN]  <= rd_sec_en;
          hrdata[BIT_SEC_RUNNING] <= secondary_clock_running;
        end
        OFF_OSC_TUNE: begin
          hrdata[BIT_LOW_FREQ_SRC] <= rd_low_freq;
        end
        OFF_SLEEP_CMD: begin
          hrdata[1:0] <= next_pm_state;
        end
        default: begin
          hrdata <= 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Levels of the source clocks are only needed as edges
  logic unused_lvls;
  assign unused_lvls = prim_lvl ^ sec_lvl ^ lprc_lvl ^ iosc_lvl
                       ^ (|hsize);
endmodule
`default_nettype wire

// ===== scsc_top_sva.sv
// Checker for the system clock select control block
`timescale 1ns/1ps
`default_nettype none
module scsc_top_sva
  import scsc_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_resetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic        hreadyout,
  input  wire logic        hresp,
  input  wire logic [1:0]  o_active_source,
  input  wire logic [2:0]  o_int_freq,
  input  wire logic        o_int_31k_from_main_internal_oscillator,
  input  wire logic        o_sys_clk_enable,
  input  wire logic        o_wdt_clk_from_lprc,
  input  wire logic        o_idle_mode,
  input  wire logic        o_sleep_mode
);
  logic        wr_q;
  logic [31:0] addr_q;
  logic [2:0]  wfreq;

  // Address phase only counts while hready is high
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_q   <= 1'b0;
      addr_q <= 32'h0000_0000;
    end else if (hready) begin
      wr_q   <= hsel & htrans[1] & hwrite;
      addr_q <= haddr;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wfreq <= FREQ_RESET;
    end else if (wr_q && hready && addr_q == OFF_OSC_CTRL) begin
      wfreq <= hwdata[BIT_FREQ_LO +: 3];
    end
  end

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  wdt_on_rc_a: assert property (o_wdt_clk_from_lprc)
    else $error("watchdog clock left the RC source");
  reset_primary_a: assert property ($rose(i_resetn) |->
    o_active_source == SRC_PRIMARY && o_int_freq == FREQ_RESET)
    else $error("reset did not restore primary source and 1 MHz");
  freq_follow_a: assert property (wr_q && hready &&
    addr_q == OFF_OSC_CTRL |-> ##2 o_int_freq == wfreq)
    else $error("frequency output did not follow the written code");
  low_freq_a: assert property (o_int_31k_from_main_internal_oscillator |->
    o_int_freq == FREQ_31K)
    else $error("divided 31 kHz chosen with a nonzero code");
  switch_resume_a: assert property ($changed(o_active_source) |->
    o_sys_clk_enable && !$past(o_sys_clk_enable, 2))
    else $error("source changed outside the end of a pause");
  pause_min_a: assert property ($fell(o_sys_clk_enable) |->
    !o_sys_clk_enable [*8])
    else $error("clock pause shorter than the new-source cycles");
  pause_bound_a: assert property ($fell(o_sys_clk_enable) |->
    ##[1:200] o_sys_clk_enable)
    else $error("clock pause did not end");
  mode_excl_a: assert property (!(o_idle_mode && o_sleep_mode))
    else $error("idle and sleep both active");
endmodule

bind scsc_top scsc_top_sva u_sva (
  .i_ref_clk, .i_resetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hreadyout, .hresp, .o_active_source, .o_int_freq, .o_int_31k_from_main_internal_oscillator,
  .o_sys_clk_enable, .o_wdt_clk_from_lprc, .o_idle_mode, .o_sleep_mode
);
`default_nettype wire

// ===== scsc_tb.sv
// Register-level testbench for the system clock select control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  miscompares++; $display("wrong value at %0t: %h not %h", $time, g, e); \
  end end
module tb;
  import scsc_pkg::*;
  logic        i_ref_clk, i_resetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, o_active_source;
  logic [2:0]  hsize, o_int_freq;
  logic        i_primary_clk, i_secondary_clk, i_lprc_clk, i_main_internal_oscillator_clk;
  logic        i_ost_expired, i_int_stable, i_two_speed_startup_config;
  logic        o_int_31k_from_main_internal_oscillator, o_sys_clk_enable, o_wdt_clk_from_lprc;
  logic        o_idle_mode, o_sleep_mode;
  int          miscompares, samples_checked;

  assign hready = hreadyout;

  scsc_top dut (
    .i_ref_clk, .i_resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .i_primary_clk, .i_secondary_clk,
    .i_lprc_clk, .i_main_internal_oscillator_clk, .i_ost_expired, .i_int_stable,
    .i_two_speed_startup_config, .o_active_source, .o_int_freq,
    .o_int_31k_from_main_internal_oscillator, .o_sys_clk_enable, .o_wdt_clk_from_lprc,
    .o_idle_mode, .o_sleep_mode
  );

  // Source clocks stay well below half the reference rate for the syncs
  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    i_primary_clk = 1'b0;
    forever #36 i_primary_clk = ~i_primary_clk;
  end
  // Secondary runs steadily from time zero, so it is stable before sleep
  initial begin
    i_secondary_clk = 1'b0;
    forever #44 i_secondary_clk = ~i_secondary_clk;
  end
  initial begin
    i_lprc_clk = 1'b0;
    forever #52 i_lprc_clk = ~i_lprc_clk;
  end
  initial begin
    i_main_internal_oscillator_clk = 1'b0;
    forever #28 i_main_internal_oscillator_clk = ~i_main_internal_oscillator_clk;
  end

  task automatic stop_test;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic hwait;
    int n;
    n = 0;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      miscompares++;
      stop_test();
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge i_ref_clk);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    hwait();
    htrans <= 2'h0;
    hwdata <= d;
    hwait();
    r = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    `CHK(x, e)
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  // Waits for the switch to finish; a lost switch ends the run
  task automatic wait_src(input logic [1:0] e);
    int n;
    n = 0;
    while (!(o_active_source === e && o_sys_clk_enable === 1'b1)
           && n < 400) begin
      @(posedge i_ref_clk);
      n++;
    end
    if (n >= 400) begin
      miscompares++;
      stop_test();
    end
    cyc(3);
  endtask

  initial begin
    i_resetn                   = 1'b0;
    hsel                       = 1'b1;
    haddr                      = 32'h0000_0000;
    htrans                     = 2'h0;
    hwrite                     = 1'b0;
    hsize                      = 3'h2;
    hwdata                     = 32'h0000_0000;
    i_ost_expired              = 1'b0;
    i_int_stable               = 1'b0;
    i_two_speed_startup_config = 1'b1;
    miscompares                = 0;
    samples_checked            = 0;
    repeat (8) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    cyc(5);
    `CHK(o_active_source, SRC_PRIMARY)
    `CHK(o_int_freq, FREQ_RESET)
    `CHK(o_wdt_clk_from_lprc, 1'b1)
    rdc(OFF_OSC_CTRL, 32'h0000_0048);
    wr(32'h0000_0010, 32'hFFFF_FFFF);
    rdc(32'h0000_0010, 32'h0000_0000);
    @(posedge i_ref_clk) i_two_speed_startup_config <= 1'b0;
    cyc(5);
    rdc(OFF_OSC_CTRL, 32'h0000_0040);
    @(posedge i_ref_clk) i_ost_expired <= 1'b1;
    cyc(5);
    rdc(OFF_OSC_CTRL, 32'h0000_0048);
    wr(OFF_OSC_TUNE, 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      wr(OFF_OSC_CTRL, 32'(i << 4));
      cyc(3);
      `CHK(o_int_freq, 3'(i))
      `CHK(o_int_31k_from_main_internal_oscillator, 1'b0)
      rdc(OFF_OSC_CTRL, 32'(i << 4) | 32'h0000_0008);
    end
    wr(OFF_OSC_CTRL, 32'h0000_0000);
    wr(OFF_OSC_TUNE, 32'h0000_0080);
    cyc(3);
    `CHK(o_int_31k_from_main_internal_oscillator, 1'b1)
    rdc(OFF_OSC_TUNE, 32'h0000_0080);
    wr(OFF_OSC_TUNE, 32'h0000_0000);
    cyc(3);
    `CHK(o_int_31k_from_main_internal_oscillator, 1'b0)
    @(posedge i_ref_clk) i_int_stable <= 1'b1;
    wr(OFF_OSC_CTRL, 32'h0000_0072);
    wait_src(2'h2);
    `CHK(o_int_freq, 3'h7)
    rdc(OFF_OSC_CTRL, 32'h0000_0076);
    wr(OFF_OSC_CTRL, 32'h0000_0063);
    cyc(3);
    `CHK(o_int_freq, 3'h6)
    `CHK(o_active_source, 2'h2)
    rdc(OFF_OSC_CTRL, 32'h0000_0067);
    @(posedge i_ref_clk) i_resetn <= 1'b0;
    cyc(2);
    `CHK(o_active_source, SRC_PRIMARY)
    @(posedge i_ref_clk) i_resetn <= 1'b1;
    cyc(5);
    rdc(OFF_OSC_CTRL, 32'h0000_0048);
    wr(OFF_TMR1_CTRL, 32'h0000_0008);
    wr(OFF_OSC_CTRL, 32'h0000_0041);
    wait_src(SRC_SECONDARY);
    rdc(OFF_TMR1_CTRL, 32'h0000_0048);
    rdc(OFF_OSC_CTRL, 32'h0000_0041);
    for (int k = 0; k < 2; k++) begin
      wr(OFF_OSC_CTRL, (k == 1) ? 32'h0000_00C1 : 32'h0000_0041);
      wr(OFF_SLEEP_CMD, 32'h0000_0001);
      cyc(2);
      `CHK(o_idle_mode, 1'(k))
      `CHK(o_sleep_mode, 1'(1 - k))
      rdc(OFF_SLEEP_CMD, 32'(2 - k));
      wr(OFF_SLEEP_CMD, 32'h0000_0000);
      cyc(2);
      `CHK(o_idle_mode | o_sleep_mode, 1'b0)
    end
    wr(OFF_TMR1_CTRL, 32'h0000_0000);
    wr(OFF_SLEEP_CMD, 32'h0000_0001);
    cyc(2);
    `CHK(o_sleep_mode | o_idle_mode, 1'b0)
    wr(OFF_OSC_CTRL, 32'h0000_0040);
    wait_src(SRC_PRIMARY);
    rdc(OFF_OSC_CTRL, 32'h0000_0048);
    stop_test();
  end
endmodule
`default_nettype wire
